/* File: hw/asrc_pkg.sv */
// constants for the host-side controller of a 16k x 4 split-io static ram
package asrc_pkg;
  localparam int unsigned ADDR_W       = 14;
  localparam int unsigned DATA_W       = 4;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // least times in ns, rounded up to cycles, at least one
  localparam int unsigned ADDR_TO_END_NS = 17;
  localparam int unsigned DATA_TO_END_NS = 10;
  localparam int unsigned ACCESS_NS      = 20;
  localparam int unsigned WRITE_FLOAT_NS = 6;
  localparam int unsigned ADDR_TO_END_CYC =
    (ADDR_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_TO_END_CYC =
    (DATA_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_FLOAT_CYC =
    (WRITE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe timer load in cycles covers address and data setup, strobe stays low one cycle longer
  localparam int unsigned STROBE_CYC =
    (ADDR_TO_END_CYC > DATA_TO_END_CYC) ? ADDR_TO_END_CYC : DATA_TO_END_CYC;
  localparam logic [3:0] CNT_STROBE = 4'(STROBE_CYC);
  localparam logic [3:0] CNT_ACCESS = 4'(ACCESS_CYC + 1);
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  typedef enum logic [4:0] {
    ASRC_IDLE  = 5'b0_0001,
    ASRC_SETUP = 5'b0_0010,
    ASRC_WSTRB = 5'b0_0100,
    ASRC_RDACC = 5'b0_1000,
    ASRC_DONE  = 5'b1_0000
  } asrc_state_type;
endpackage : asrc_pkg

/* File: hw/asrc_cnt.sv */
// small down counter used for strobe and access timing
`timescale 1ns/100ps
`default_nettype none
module asrc_cnt (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [3:0] i_value,
  output logic            o_zero
);
  logic [3:0] cnt_q;
  // load wins, otherwise count down to zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q <= asrc_pkg::CNT_ZERO;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != asrc_pkg::CNT_ZERO) begin
      cnt_q <= cnt_q - asrc_pkg::CNT_ONE;
    end
  end
  assign o_zero = (cnt_q == asrc_pkg::CNT_ZERO);
endmodule : asrc_cnt
`default_nettype wire

/* File: hw/asrc_host.sv */
// host controller driving a 16k x 4 static ram with separate data pins
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - both selects low to address the memory
// - address changes only with strobe high
// - read: strobe high, selects and enable low
// - address stable before write ends
// - write data set up, held after end
module asrc_host (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_req_valid,
  input  wire logic                        i_req_write,
  input  wire logic [asrc_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [asrc_pkg::DATA_W-1:0] i_req_wdata,
  output logic                             o_req_ready,
  output logic                             o_rsp_valid,
  output logic      [asrc_pkg::DATA_W-1:0] o_rsp_rdata,
  output logic      [asrc_pkg::ADDR_W-1:0] o_word_address_lines,
  output logic      [asrc_pkg::DATA_W-1:0] o_write_data_lines,
  input  wire logic [asrc_pkg::DATA_W-1:0] i_read_data_lines,
  output logic                             o_select_first_n,
  output logic                             o_select_second_n,
  output logic                             o_write_n,
  output logic                             o_out_enable_n
);
  asrc_pkg::asrc_state_type state_q, state_d;
  logic [asrc_pkg::ADDR_W-1:0] addr_q;
  logic [asrc_pkg::DATA_W-1:0] wdata_q, rdata_q;
  logic                        is_write_q, rsp_q;
  logic                        sel_q, we_q, oe_q;
  logic                        cnt_load, cnt_zero;
  logic [3:0]                  cnt_value;
  wire take = (state_q == asrc_pkg::ASRC_IDLE) && i_req_valid;
  wire in_setup = (state_q == asrc_pkg::ASRC_SETUP);
  wire in_wstrb = (state_q == asrc_pkg::ASRC_WSTRB);
  wire in_rdacc = (state_q == asrc_pkg::ASRC_RDACC);

  asrc_cnt u_cnt (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (cnt_load),
    .i_value   (cnt_value),
    .o_zero    (cnt_zero)
  );

  // timer loads on entry to strobe and read access phases
  assign cnt_load  = in_setup;
  assign cnt_value = is_write_q ? asrc_pkg::CNT_STROBE : asrc_pkg::CNT_ACCESS;

  // sequence: setup with strobes high, strobe phase, release
  always_comb begin
    state_d = state_q;
    case (state_q)
      asrc_pkg::ASRC_IDLE: begin
        if (i_req_valid) state_d = asrc_pkg::ASRC_SETUP;
      end
      asrc_pkg::ASRC_SETUP: begin
        state_d = is_write_q ? asrc_pkg::ASRC_WSTRB : asrc_pkg::ASRC_RDACC;
      end
      asrc_pkg::ASRC_WSTRB: begin
        if (cnt_zero) state_d = asrc_pkg::ASRC_DONE;
      end
      asrc_pkg::ASRC_RDACC: begin
        if (cnt_zero) state_d = asrc_pkg::ASRC_DONE;
      end
      asrc_pkg::ASRC_DONE: begin
        state_d = asrc_pkg::ASRC_IDLE;
      end
      default: begin
        state_d = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) state_q <= asrc_pkg::ASRC_IDLE;
    else       state_q <= state_d;
  end

  // address latched only while strobes are high
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr_q     <= '0;
      wdata_q    <= '0;
      is_write_q <= 1'b0;
    end else if (take) begin
      addr_q     <= i_req_addr;
      wdata_q    <= i_req_wdata;
      is_write_q <= i_req_write;
    end
  end

  // selects low for the whole access, deselected in idle
  // write strobe falls with selects so outputs stay floated
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      we_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      sel_q <= (state_d == asrc_pkg::ASRC_WSTRB) || (state_d == asrc_pkg::ASRC_RDACC);
      we_q  <= (state_d == asrc_pkg::ASRC_WSTRB);
      oe_q  <= (state_d == asrc_pkg::ASRC_RDACC);
    end
  end

  // capture read word on the last access cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= in_rdacc && cnt_zero;
      if (in_rdacc && cnt_zero) rdata_q <= i_read_data_lines;
    end
  end

  // address and data held through strobe and until the next request is taken
  assign o_word_address_lines = addr_q;
  assign o_write_data_lines   = wdata_q;
  // strobe and both selects low together only in strobe phase
  assign o_select_first_n     = ~sel_q;
  assign o_select_second_n    = ~sel_q;
  assign o_write_n            = ~we_q;
  assign o_out_enable_n       = ~oe_q;
  assign o_req_ready          = (state_q == asrc_pkg::ASRC_IDLE);
  assign o_rsp_valid          = rsp_q;
  assign o_rsp_rdata          = rdata_q;

  // helper: address of previous cycle
  logic [asrc_pkg::ADDR_W-1:0] addr_prev_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) addr_prev_q <= '0;
    else       addr_prev_q <= o_word_address_lines;
  end

  sequence s_write_strobe;
    !o_write_n [*1];
  endsequence

  a_addr_stable_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!o_write_n && !o_select_first_n) |-> (o_word_address_lines == addr_prev_q))
    else $error("address moved during write");
  a_write_needs_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_write_n |-> (!o_select_first_n && !o_select_second_n))
    else $error("write strobe without both selects");
  a_read_no_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_out_enable_n |-> (o_write_n && !o_select_first_n))
    else $error("read drive with write strobe low");
  a_write_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_write_n) |-> !o_write_n [*2])
    else $error("write strobe too short");
  a_data_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_write_n) |-> $stable(o_write_data_lines))
    else $error("write data changed at write end");
  a_select_with_strobe: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_write_n) |-> $fell(o_select_first_n))
    else $error("select not asserted with strobe");
  a_standby_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_q == asrc_pkg::ASRC_IDLE) |-> (o_select_first_n && o_select_second_n))
    else $error("selected while idle");
  a_read_response: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_out_enable_n) |-> ##[1:4] o_rsp_valid)
    else $error("read response late");
  a_write_ends: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_write_strobe |-> ##[1:3] o_write_n)
    else $error("write strobe never released");
  // strobe only in strobe phase, never at a take
  a_strobe_phase: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_write_n |-> in_wstrb)
    else $error("write strobe outside strobe phase");
endmodule : asrc_host
`default_nettype wire

/* File: sim/asrc_sram_model.sv */
// behavioural 16k x 4 static ram, floating-output variant
`timescale 1ns/100ps
`default_nettype none
module asrc_sram_model #(
  parameter bit TRACK = 1'b0  // 1: outputs follow the inputs during a write with output enable low
) (
  input  wire logic [13:0] i_addr,
  input  wire logic [3:0]  i_din,
  input  wire logic        i_sel1_n,
  input  wire logic        i_sel2_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic      [3:0]  o_dout
);
  logic [3:0] mem [0:16383];
  logic [3:0] last_q = 4'h0;
  wire sel = !i_sel1_n && !i_sel2_n;
  wire drv = sel && i_we_n && !i_oe_n;
  // tracking variant shows the input word while writing with output enable low
  wire trk = TRACK && sel && !i_we_n && !i_oe_n;
  // store during overlap, ends at first strobe rise
  always @* if (sel && !i_we_n) mem[i_addr] = i_din;
  // remember the last word driven
  always @* if (drv) last_q = mem[i_addr];
  // read word on read, input word when tracking, otherwise the inverted last word, 5 ns lag
  assign #5 o_dout = drv ? mem[i_addr] : (trk ? i_din : ~last_q);
endmodule : asrc_sram_model
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the static ram host controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk, rst, vld, wr, rdy, rv, s1, s2, we, oe;
  logic        pw = 1'b1;
  logic [13:0] ra, a, pa;
  logic [3:0]  wd, rd, d, y, pd;
  int          err_count, n_checks;
  int          wl = 0;
  asrc_host uut (.i_sys_clk(clk), .i_rst(rst), .i_req_valid(vld), .i_req_write(wr),
    .i_req_addr(ra), .i_req_wdata(wd), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rd), .o_word_address_lines(a), .o_write_data_lines(d),
    .i_read_data_lines(y), .o_select_first_n(s1), .o_select_second_n(s2),
    .o_write_n(we), .o_out_enable_n(oe));
  asrc_sram_model ram (.i_addr(a), .i_din(d), .i_sel1_n(s1), .i_sel2_n(s2),
    .i_we_n(we), .i_oe_n(oe), .o_dout(y));
  // clock at 50 ns
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic hang;
    err_count++;
    $display("MISMATCH t=%0t handshake timed out", $time);
    report_and_stop();
  endtask : hang
  // one request, waits for ready and, on a read, for read data
  task automatic xfer(input logic w, input logic [13:0] ad, input logic [3:0] dt);
    int n;
    n = 0;
    while (rdy !== 1'b1) begin
      @(posedge clk) #1;
      if (++n > 30) hang();
    end
    vld = 1;
    wr = w;
    ra = ad;
    wd = dt;
    @(posedge clk) #1;
    vld = 0;
    n = 0;
    while (!w && rv !== 1'b1) begin
      @(posedge clk) #1;
      if (++n > 30) hang();
    end
  endtask : xfer
  task automatic rd_chk(input logic [13:0] ad, input logic [3:0] ex);
    xfer(1'b0, ad, 4'h0);
    chk(14'(rd), 14'(ex));
  endtask : rd_chk
  // pins watched every cycle
  always @(posedge clk) if (!rst) begin
    chk(14'(s1), 14'(s2));
    if (!we && !pw) chk(a, pa);
    if (!we && !pw) chk(14'(d), 14'(pd));
    if (!oe) chk(14'(we), 14'h0001);
    if (we && !pw) chk(14'(wl >= asrc_pkg::STROBE_CYC), 14'h0001);
    wl <= we ? 0 : wl + 1;
    pw <= we;
    pa <= a;
    pd <= d;
  end
  task automatic sc_reset;
    chk(14'({s1, we, oe, rdy, rv}), 14'h001e);
  endtask : sc_reset
  task automatic sc_edges;
    xfer(1'b1, 14'h0000, 4'h5);
    xfer(1'b1, 14'h3fff, 4'ha);
    rd_chk(14'h0000, 4'h5);
    rd_chk(14'h3fff, 4'ha);
  endtask : sc_edges
  // every data value at spread addresses
  task automatic sc_pattern;
    for (int i = 0; i < 16; i++) xfer(1'b1, 14'(i * 1021), 4'(i));
    for (int i = 0; i < 16; i++) rd_chk(14'(i * 1021), 4'(15 - i) ^ 4'hf);
  endtask : sc_pattern
  // back-to-back overwrite keeps the later word
  task automatic sc_overwrite;
    xfer(1'b1, 14'h0155, 4'h3);
    xfer(1'b1, 14'h0155, 4'hc);
    rd_chk(14'h0155, 4'hc);
  endtask : sc_overwrite
  initial begin
    rst = 1;
    vld = 0;
    wr = 0;
    ra = 0;
    wd = 0;
    err_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    #1 rst = 0;
    sc_reset();
    sc_edges();
    sc_pattern();
    sc_overwrite();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
